// *** verilog/psrpc_top.sv ***
// power-mode, configuration and self-refresh control of the pseudo-static RAM
//
// Contract
// - clearing primary_config_reg bit 15 enters deep_power_down within entry delay, refresh stops
// - array contents are invalid after deep_power_down
// - deep_power_down ends on chip select low-then-high or hardware reset
// - in deep_power_down only chip select and hardware reset are observed; the code still reflects hot grade in bits 1:0 and status
// - refresh_sleep_config bit 6 selects single-ended (1, default) or differential clock
// - writing one to bit 5 enters retention_sleep, contents kept
// - chip select low leaves retention_sleep and clears bit 5
// - hardware reset also ends retention_sleep and disables refresh
// - bits 4:2 restrict self-refresh to full, bottom, none or top region
// - read-only bits 1:0 report max select low time: 01 4us, 10 1us
// - rows are refreshed only while no access runs; pending refresh waits
// - access starting with refresh pending drives rw_data_strobe high in command phase
// - single-row refreshes spread over 64 ms or 16 ms for 4096 rows
// - stable bus_clock for access time plus 30 ns enters clock stop
// - with chip select high the interface stands by and ignores other pins; the code still acts on hardware reset and hot grade
// - without extra latency rw_data_strobe stays low in command phase
// - after deep_power_down exit all configuration returns to defaults
`timescale 1ns/1ns
`include "psrpc_regs.svh"
module psrpc_top #(
  parameter int                 ROW_W    = 12,
  parameter int                 OWE_W    = 3,
  parameter int                 COOL_CYC = `PSRPC_COOL_CYC,
  parameter int                 HOT_CYC  = `PSRPC_HOT_CYC,
  parameter int                 DPDIN_CYC = `PSRPC_DPDIN_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_clk_en,
  input  wire logic [1:0]       i_addr,
  input  wire logic [15:0]      i_wr_data,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [15:0]      o_rd_data,
  input  wire logic             i_cs_n,
  input  wire logic             i_bus_clock,
  input  wire logic             i_hw_reset_n,
  input  wire logic             i_hot_grade,
  output logic                  o_rw_data_strobe_out,
  output logic                  o_rw_data_strobe_oe,
  output logic                  o_deep_power_down,
  output logic                  o_retention_sleep,
  output logic                  o_refresh_active,
  output logic      [ROW_W-1:0] o_refresh_row,
  output logic                  o_clock_stop,
  output logic                  o_single_ended_clk,
  output logic                  o_data_invalid
);

  localparam logic [7:0] STOP_CYC = 8'(`PSRPC_STOP_CYC);
  localparam logic [2:0] REF_CYC  = 3'(`PSRPC_REF_CYC);
  localparam logic [1:0] CA_CLKS  = 2'(`PSRPC_CA_CLKS);

  function automatic logic hit(input logic [1:0] addr, input logic [1:0] off);
    hit = (addr == off);
  endfunction

  // refresh region membership
  function automatic logic in_region(input logic [2:0] code, input logic [ROW_W-1:0] row);
    case (code)
      3'h0:    in_region = 1'b1;
      3'h1:    in_region = ~row[ROW_W-1];
      3'h2:    in_region = ~|row[ROW_W-1 -: 2];
      3'h3:    in_region = ~|row[ROW_W-1 -: 3];
      3'h5:    in_region = row[ROW_W-1];
      3'h6:    in_region = &row[ROW_W-1 -: 2];
      3'h7:    in_region = &row[ROW_W-1 -: 3];
      default: in_region = 1'b0;
    endcase
  endfunction

  psrpc_pkg::psrpc_pins_s pins_a;
  psrpc_pkg::psrpc_pins_s pins_s;
  psrpc_pkg::psrpc_pw_e   pw_ff;
  psrpc_pkg::psrpc_pw_e   nxt_pw;

  logic             cs_n_q_ff;
  logic             ck_q_ff;
  logic [15:0]      cr0_ff;
  logic             clk_type_ff;
  logic [2:0]       region_ff;
  logic [7:0]       ent_cnt_ff;
  logic             dpd_ff;
  logic             sleep_ff;
  logic             invalid_ff;
  logic [OWE_W-1:0] owe_ff;
  logic [2:0]       busy_cnt_ff;
  logic             busy_ff;
  logic [ROW_W-1:0] row_ff;
  logic [1:0]       ca_cnt_ff;
  logic             extra_ff;
  logic             rw_data_strobe_oe_ff;
  logic [7:0]       idle_cnt_ff;
  logic             stop_ff;
  logic [15:0]      rd_data_ff;

  logic             cs_fall;
  logic             cs_rise;
  logic             ck_rise;
  logic             ck_edge;
  logic             soft_rst;
  logic             restore;
  logic             run;
  logic             tick;
  logic             rf_start;
  logic             wr_cr0;
  logic             wr_cr1;
  logic [1:0]       csm_code;
  logic [15:0]      cr1_view;
  logic [15:0]      stat_view;

  assign pins_a = '{cs_n: i_cs_n, bus_clock: i_bus_clock, hw_reset_n: i_hw_reset_n, hot_grade: i_hot_grade};

  psrpc_sync #(
    .W   (4),
    .RST (4'hA)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clk_en (i_clk_en),
    .i_async  (pins_a),
    .o_sync   (pins_s)
  );

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cs_n_q_ff <= 1'b1;
      ck_q_ff   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      cs_n_q_ff <= pins_s.cs_n;
      ck_q_ff   <= pins_s.bus_clock;
    end
  end

  assign cs_fall  = cs_n_q_ff & ~pins_s.cs_n;
  assign cs_rise  = ~cs_n_q_ff & pins_s.cs_n;
  assign ck_rise  = ~ck_q_ff & pins_s.bus_clock;
  assign ck_edge  = ck_q_ff ^ pins_s.bus_clock;
  assign soft_rst = ~pins_s.hw_reset_n;
  assign csm_code = pins_s.hot_grade ? `PSRPC_CSM_1US : `PSRPC_CSM_4US;

  // register writes are refused in deep power down
  assign wr_cr0 = i_wr & hit(i_addr, `PSRPC_ADDR_CR0) & (pw_ff != psrpc_pkg::PSRPC_PW_DPD);
  assign wr_cr1 = i_wr & hit(i_addr, `PSRPC_ADDR_CR1) & (pw_ff != psrpc_pkg::PSRPC_PW_DPD);

  // power state sequencing
  always_comb
  begin
    nxt_pw = pw_ff;
    case (pw_ff)
      psrpc_pkg::PSRPC_PW_ACTIVE:
      begin
        if (wr_cr0 && !i_wr_data[`PSRPC_CR0_DPD_BIT])
          nxt_pw = psrpc_pkg::PSRPC_PW_DPD_ENTRY;
        else if (wr_cr1 && i_wr_data[`PSRPC_CR1_SLEEP_BIT])
          nxt_pw = psrpc_pkg::PSRPC_PW_SLEEP;
      end
      psrpc_pkg::PSRPC_PW_DPD_ENTRY:
      begin
        if (ent_cnt_ff >= 8'(DPDIN_CYC - 1))
          nxt_pw = psrpc_pkg::PSRPC_PW_DPD;
      end
      psrpc_pkg::PSRPC_PW_DPD:
      begin
        if (cs_rise)
          nxt_pw = psrpc_pkg::PSRPC_PW_ACTIVE;
      end
      psrpc_pkg::PSRPC_PW_SLEEP:
      begin
        if (cs_fall)
          nxt_pw = psrpc_pkg::PSRPC_PW_ACTIVE;
      end
      default: nxt_pw = psrpc_pkg::PSRPC_PW_ACTIVE;
    endcase
    if (soft_rst)
      nxt_pw = psrpc_pkg::PSRPC_PW_ACTIVE;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pw_ff    <= psrpc_pkg::PSRPC_PW_ACTIVE;
      dpd_ff   <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      pw_ff    <= nxt_pw;
      dpd_ff   <= (nxt_pw == psrpc_pkg::PSRPC_PW_DPD);
      sleep_ff <= (nxt_pw == psrpc_pkg::PSRPC_PW_SLEEP);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ent_cnt_ff <= '0;
    else if (i_clk_en)
    begin
      if (pw_ff == psrpc_pkg::PSRPC_PW_DPD_ENTRY)
        ent_cnt_ff <= ent_cnt_ff + 1'b1;
      else
        ent_cnt_ff <= '0;
    end
  end

  // defaults come back after power-down exit or hardware reset
  assign restore = soft_rst | ((pw_ff == psrpc_pkg::PSRPC_PW_DPD) & cs_rise);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cr0_ff      <= `PSRPC_CR0_RST;
      clk_type_ff <= `PSRPC_CLKTYPE_RST;
      region_ff   <= `PSRPC_REGION_RST;
    end
    else if (i_clk_en)
    begin
      if (restore)
      begin
        cr0_ff      <= `PSRPC_CR0_RST;
        clk_type_ff <= `PSRPC_CLKTYPE_RST;
        region_ff   <= `PSRPC_REGION_RST;
      end
      else
      begin
        if (wr_cr0)
          cr0_ff <= i_wr_data;
        if (wr_cr1)
        begin
          clk_type_ff <= i_wr_data[`PSRPC_CR1_CLKTYPE_BIT];
          region_ff   <= i_wr_data[`PSRPC_CR1_REGION_LSB +: 3];
        end
      end
    end
  end

  // contents lost in deep power down or by hardware reset; status read clears, set wins
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      invalid_ff <= 1'b0;
    else if (i_clk_en)
    begin
      if ((pw_ff == psrpc_pkg::PSRPC_PW_DPD) || soft_rst)
        invalid_ff <= 1'b1;
      else if (i_rd && hit(i_addr, `PSRPC_ADDR_STAT))
        invalid_ff <= 1'b0;
    end
  end

  // refresh halts in power down and under hardware reset
  assign run = ~soft_rst & (pw_ff != psrpc_pkg::PSRPC_PW_DPD_ENTRY) & (pw_ff != psrpc_pkg::PSRPC_PW_DPD);

  psrpc_refresh_timer #(
    .CNT_W    (16),
    .COOL_CYC (COOL_CYC),
    .HOT_CYC  (HOT_CYC)
  ) u_timer (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clk_en (i_clk_en),
    .i_run    (run),
    .i_hot    (pins_s.hot_grade),
    .o_tick   (tick)
  );

  // a row is taken only while the bus is idle
  assign rf_start = run & (owe_ff != '0) & ~busy_ff & pins_s.cs_n;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      owe_ff <= '0;
    else if (i_clk_en)
    begin
      if (!run)
        owe_ff <= '0;
      else if (tick && !rf_start && !(&owe_ff))
        owe_ff <= owe_ff + 1'b1;
      else if (rf_start && !tick)
        owe_ff <= owe_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy_ff     <= 1'b0;
      busy_cnt_ff <= '0;
      row_ff      <= '0;
    end
    else if (i_clk_en)
    begin
      if (!run)
      begin
        busy_ff     <= 1'b0;
        busy_cnt_ff <= '0;
      end
      else if (rf_start)
      begin
        row_ff <= row_ff + 1'b1;
        if (in_region(region_ff, row_ff))
        begin
          busy_ff     <= 1'b1;
          busy_cnt_ff <= REF_CYC - 1'b1;
        end
      end
      else if (busy_ff)
      begin
        if (busy_cnt_ff == '0)
          busy_ff <= 1'b0;
        else
          busy_cnt_ff <= busy_cnt_ff - 1'b1;
      end
    end
  end

  // command phase strobe: extra latency while refresh pending or fixed latency set
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ca_cnt_ff  <= '0;
      extra_ff   <= 1'b0;
      rw_data_strobe_oe_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (pins_s.cs_n)
      begin
        ca_cnt_ff  <= '0;
        rw_data_strobe_oe_ff <= 1'b0;
      end
      else if (cs_fall && pw_ff == psrpc_pkg::PSRPC_PW_ACTIVE)
      begin
        ca_cnt_ff  <= '0;
        rw_data_strobe_oe_ff <= 1'b1;
        extra_ff   <= cr0_ff[`PSRPC_CR0_FIXLAT_BIT] | busy_ff | (owe_ff != '0);
      end
      else if (rw_data_strobe_oe_ff && ck_rise)
      begin
        ca_cnt_ff <= ca_cnt_ff + 1'b1;
        if (ca_cnt_ff == CA_CLKS - 1'b1)
          rw_data_strobe_oe_ff <= 1'b0;
      end
    end
  end

  // clock stop after the bus clock stands still in the data phase
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      idle_cnt_ff <= '0;
      stop_ff     <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (pins_s.cs_n || rw_data_strobe_oe_ff || ck_edge || pw_ff != psrpc_pkg::PSRPC_PW_ACTIVE)
      begin
        idle_cnt_ff <= '0;
        stop_ff     <= 1'b0;
      end
      else if (idle_cnt_ff < STOP_CYC)
        idle_cnt_ff <= idle_cnt_ff + 1'b1;
      else
        stop_ff <= 1'b1;
    end
  end

  assign cr1_view = {`PSRPC_CR1_RSVD, clk_type_ff, sleep_ff, region_ff, csm_code};

  always_comb
  begin
    stat_view = '0;
    stat_view[`PSRPC_STAT_DPD]     = dpd_ff;
    stat_view[`PSRPC_STAT_SLEEP]   = sleep_ff;
    stat_view[`PSRPC_STAT_INVALID] = invalid_ff;
    stat_view[`PSRPC_STAT_REFBUSY] = busy_ff;
    stat_view[`PSRPC_STAT_CLKSTOP] = stop_ff;
    stat_view[`PSRPC_STAT_HOT]     = pins_s.hot_grade;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rd_data_ff <= '0;
    else if (i_clk_en)
    begin
      if (!i_rd)
        rd_data_ff <= '0;
      else if (hit(i_addr, `PSRPC_ADDR_CR0))
        rd_data_ff <= cr0_ff;
      else if (hit(i_addr, `PSRPC_ADDR_CR1))
        rd_data_ff <= cr1_view;
      else if (hit(i_addr, `PSRPC_ADDR_STAT))
        rd_data_ff <= stat_view;
      else
        rd_data_ff <= '0;
    end
  end

  assign o_rd_data          = rd_data_ff;
  assign o_rw_data_strobe_out         = extra_ff;
  assign o_rw_data_strobe_oe          = rw_data_strobe_oe_ff;
  assign o_deep_power_down  = dpd_ff;
  assign o_retention_sleep  = sleep_ff;
  assign o_refresh_active   = busy_ff;
  assign o_refresh_row      = row_ff;
  assign o_clock_stop       = stop_ff;
  assign o_single_ended_clk = clk_type_ff;
  assign o_data_invalid     = invalid_ff;

  a_dpd_no_refresh: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dpd_ff |-> !busy_ff && owe_ff == '0) else $error("refresh active in deep power down");

  a_dpd_marks_invalid: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(dpd_ff) && $past(i_clk_en) && $past(pw_ff == psrpc_pkg::PSRPC_PW_DPD) |-> invalid_ff)
    else $error("data not marked invalid after power down");

  a_dpd_exit_defaults: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(dpd_ff) |-> cr0_ff == `PSRPC_CR0_RST && clk_type_ff && region_ff == `PSRPC_REGION_RST)
    else $error("defaults not restored on power down exit");

  a_sleep_cs_exit: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sleep_ff && cs_fall && i_clk_en && !soft_rst |=> !sleep_ff && !cr1_view[`PSRPC_CR1_SLEEP_BIT])
    else $error("sleep not left on chip select low");

  a_rw_data_strobe_extra_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rw_data_strobe_oe_ff && (busy_ff || owe_ff != '0) && $stable(rw_data_strobe_oe_ff) && $past(busy_ff) |-> o_rw_data_strobe_out)
    else $error("strobe low while refresh pending");

  a_rw_data_strobe_plain_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(rw_data_strobe_oe_ff) && !$past(cr0_ff[`PSRPC_CR0_FIXLAT_BIT]) && !$past(busy_ff) && $past(owe_ff) == '0
    |-> !o_rw_data_strobe_out) else $error("strobe high without extra latency");

  a_refresh_bus_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(busy_ff) |-> $past(pins_s.cs_n)) else $error("refresh started during access");

  a_region_none: assert property (@(posedge i_clk) disable iff (!i_resetn)
    region_ff == 3'h4 && $past(region_ff) == 3'h4 |-> !$rose(busy_ff)) else $error("refresh with no region");

  a_csm_code_legal: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cr1_view[1:0] == `PSRPC_CSM_4US || cr1_view[1:0] == `PSRPC_CSM_1US) else $error("bad select low code");

  a_standby_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(pins_s.cs_n) && $past(i_clk_en) |-> !rw_data_strobe_oe_ff && !stop_ff) else $error("active in standby");

endmodule // psrpc_top

// *** include/psrpc_regs.svh ***
// register offsets, field positions, reset values and timing figures
`ifndef PSRPC_REGS_SVH
`define PSRPC_REGS_SVH

`define PSRPC_ADDR_CR0        2'h0
`define PSRPC_ADDR_CR1        2'h1
`define PSRPC_ADDR_STAT       2'h2

`define PSRPC_CR0_RST         16'h8008
`define PSRPC_CR0_DPD_BIT     15
`define PSRPC_CR0_FIXLAT_BIT  3

`define PSRPC_CR1_RSVD        9'h1FF
`define PSRPC_CR1_CLKTYPE_BIT 6
`define PSRPC_CR1_SLEEP_BIT   5
`define PSRPC_CR1_REGION_LSB  2
`define PSRPC_CLKTYPE_RST     1'h1
`define PSRPC_REGION_RST      3'h0
`define PSRPC_CSM_4US         2'h1
`define PSRPC_CSM_1US         2'h2

`define PSRPC_STAT_DPD        0
`define PSRPC_STAT_SLEEP      1
`define PSRPC_STAT_INVALID    2
`define PSRPC_STAT_REFBUSY    3
`define PSRPC_STAT_CLKSTOP    4
`define PSRPC_STAT_HOT        5

`define PSRPC_CLK_NS          50
`define PSRPC_WIN_COOL_MS     64
`define PSRPC_WIN_HOT_MS      16
`define PSRPC_ROWS            4096
`define PSRPC_DPDIN_US        3
`define PSRPC_INITIAL_ACCESS_TIME_NS         35
`define PSRPC_STOP_MARGIN_NS  30
`define PSRPC_CA_CLKS         3
`define PSRPC_REF_CYC         4

// longest times round down, least times round up
`define PSRPC_COOL_CYC  ((`PSRPC_WIN_COOL_MS * 1000000) / (`PSRPC_ROWS * `PSRPC_CLK_NS))
`define PSRPC_HOT_CYC   ((`PSRPC_WIN_HOT_MS * 1000000) / (`PSRPC_ROWS * `PSRPC_CLK_NS))
`define PSRPC_DPDIN_CYC ((`PSRPC_DPDIN_US * 1000) / `PSRPC_CLK_NS)
`define PSRPC_STOP_CYC  ((`PSRPC_INITIAL_ACCESS_TIME_NS + `PSRPC_STOP_MARGIN_NS + `PSRPC_CLK_NS - 1) / `PSRPC_CLK_NS)

`endif

// *** include/psrpc_pkg.sv ***
// types shared by the power and refresh control block
package psrpc_pkg;

  typedef enum logic [1:0] {
    PSRPC_PW_ACTIVE,
    PSRPC_PW_DPD_ENTRY,
    PSRPC_PW_DPD,
    PSRPC_PW_SLEEP
  } psrpc_pw_e;

  typedef struct packed {
    logic cs_n;
    logic bus_clock;
    logic hw_reset_n;
    logic hot_grade;
  } psrpc_pins_s;

endpackage

// *** verilog/psrpc_sync.sv ***
// two-flop synchroniser for the pin group
`timescale 1ns/1ns
module psrpc_sync #(
  parameter int                 W   = 4,
  parameter logic [W-1:0]       RST = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_clk_en,
  input  wire logic [W-1:0]     i_async,
  output logic      [W-1:0]     o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_ff <= RST;
      sync_ff <= RST;
    end
    else if (i_clk_en)
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // psrpc_sync

// *** verilog/psrpc_refresh_timer.sv ***
// per-row refresh tick generator, interval chosen by temperature grade
`timescale 1ns/1ns
module psrpc_refresh_timer #(
  parameter int          CNT_W    = 16,
  parameter int          COOL_CYC = 312,
  parameter int          HOT_CYC  = 78
) (
  input  wire logic      i_clk,
  input  wire logic      i_resetn,
  input  wire logic      i_clk_en,
  input  wire logic      i_run,
  input  wire logic      i_hot,
  output logic           o_tick
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] limit;
  logic             tick_ff;

  assign limit = i_hot ? CNT_W'(HOT_CYC - 1) : CNT_W'(COOL_CYC - 1);

  // evenly spaced single-row ticks
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      tick_ff <= 1'b0;
      if (!i_run)
        cnt_ff <= '0;
      else if (cnt_ff >= limit)
      begin
        cnt_ff  <= '0;
        tick_ff <= 1'b1;
      end
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign o_tick = tick_ff;

endmodule // psrpc_refresh_timer

// *** dv/psrpc_host_model.sv ***
// host controller model driving chip select and the bus clock
`timescale 1ns/1ns
module psrpc_host_model (
  input  wire logic i_clk,
  output logic      o_cs_n,
  output logic      o_bus_clock
);
  initial
  begin
    o_cs_n      = 1'b1;
    o_bus_clock = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // clock pulses before a pause, pause in clocks, pulses after
  // low time stays inside the select-low limit
  // at least 4 clocks low, enough to leave either low-power state
  task automatic frame(input int pre, input int stall, input int post);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    tick(2);
    for (int e = 0; e < pre + post; e++)
    begin
      o_bus_clock <= 1'b1;
      tick(4);
      o_bus_clock <= 1'b0;
      tick(4);
      if (e == pre - 1)
        tick(stall);
    end
    if (pre + post == 0)
      tick(stall);
    tick(2);
    o_cs_n <= 1'b1;
  endtask
endmodule // psrpc_host_model

// *** dv/psram_power_refresh_ctrl_bench.sv ***
// self-checking bench for the power and refresh control block
`timescale 1ns/1ns
`include "psrpc_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module psram_power_refresh_ctrl_bench;
  logic        clk;
  logic        resetn;
  logic        clk_en;
  logic        wr;
  logic        rd;
  logic        hot;
  logic        hw_n;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [15:0] v;
  wire         cs_n;
  wire         bclk;
  logic        rw_data_strobe_out;
  logic        rw_data_strobe_oe;
  logic        deep_power_down;
  logic        slp;
  logic        ref_act;
  logic        ref_q;
  logic        cstop;
  logic        se_clk;
  logic        inval;
  logic        bad_ref;
  logic [11:0] row;
  logic [11:0] step;
  int          n_errors;
  int          checks;
  int          seed;
  int          cyc;
  int          n_ref;
  int          cs_lo;
  int          g;
  int          k;

  psrpc_top #(.COOL_CYC(20), .HOT_CYC(10), .DPDIN_CYC(4)) psrpc_top_i (
    .i_clk(clk), .i_resetn(resetn), .i_clk_en(clk_en), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_cs_n(cs_n), .i_bus_clock(bclk),
    .i_hw_reset_n(hw_n), .i_hot_grade(hot), .o_rw_data_strobe_out(rw_data_strobe_out), .o_rw_data_strobe_oe(rw_data_strobe_oe),
    .o_deep_power_down(deep_power_down), .o_retention_sleep(slp), .o_refresh_active(ref_act),
    .o_refresh_row(row), .o_clock_stop(cstop), .o_single_ended_clk(se_clk), .o_data_invalid(inval));

  psrpc_host_model psrpc_host_model_i (.i_clk(clk), .o_cs_n(cs_n), .o_bus_clock(bclk));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    ref_q <= ref_act;
    cs_lo <= cs_n ? 0 : cs_lo + 1;
    cyc   <= cyc + 1;
    if (ref_act === 1'b1 && ref_q === 1'b0)
    begin
      n_ref <= n_ref + 1;
      if (cs_lo > 4)
        bad_ref <= 1'b1;
    end
    if (cyc == 30000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [15:0] x);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 x = rdata;
  endtask

  // cycles and row step between two refresh starts
  task automatic gap(output int c, output logic [11:0] s);
    logic [11:0] r0;
    int          n0;
    n0 = n_ref;
    for (k = 0; k < 100 && n_ref == n0; k++) @(negedge clk);
    n0 = n_ref;
    r0 = row;
    c  = 0;
    for (k = 0; k < 100 && n_ref == n0; k++)
    begin
      @(negedge clk);
      c++;
    end
    s = row - r0;
  endtask

  task automatic watch();
    for (k = 0; k < 30 && rw_data_strobe_oe !== 1'b1; k++) @(negedge clk);
    `CHK("strobe_oe", 1'b1, rw_data_strobe_oe)
  endtask

  function automatic logic [15:0] exp_cr1(input logic c, input logic s, input logic [2:0] r);
    exp_cr1 = {9'h1FF, c, s, r, hot ? `PSRPC_CSM_1US : `PSRPC_CSM_4US};
  endfunction

  // whether a row lies inside the chosen refresh region
  function automatic logic in_area(input logic [2:0] c, input logic [11:0] w);
    case (c)
      3'h0:    in_area = 1'b1;
      3'h1:    in_area = w < 12'h800;
      3'h2:    in_area = w < 12'h400;
      3'h3:    in_area = w < 12'h200;
      3'h5:    in_area = w >= 12'h800;
      3'h6:    in_area = w >= 12'hC00;
      3'h7:    in_area = w >= 12'hE00;
      default: in_area = 1'b0;
    endcase
  endfunction

  initial
  begin
    seed = 45198;
    {resetn, wr, rd, hot, addr, wdata, ref_q, bad_ref} = '0;
    {clk_en, hw_n} = 2'h3;
    {n_errors, checks, cyc, n_ref, cs_lo} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(2'h0, d);
    `CHK("cr0_reset", `PSRPC_CR0_RST, d)
    rd_reg(2'h1, d);
    `CHK("cr1_reset", exp_cr1(1'b1, 1'b0, 3'h0), d)
    rd_reg(2'h3, d);
    `CHK("unmapped", 16'h0000, d)
    `CHK("single_ended", 1'b1, se_clk)
    `CHK("standby_oe", 1'b0, rw_data_strobe_oe)
    $display("test reset done");
    gap(g, step);
    `CHK("cool_gap", 20, g)
    `CHK("row_step", 12'h001, step)
    @(posedge clk);
    hot <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(2'h1, d);
    `CHK("cr1_hot", exp_cr1(1'b1, 1'b0, 3'h0), d)
    gap(g, step);
    gap(g, step);
    `CHK("hot_gap", 10, g)
    @(posedge clk);
    hot <= 1'b0;
    clk_en <= 1'b0;
    @(posedge clk);
    step = row;
    repeat (30) @(posedge clk);
    `CHK("freeze_row", step, row)
    clk_en <= 1'b1;
    $display("test refresh rate done");
    for (int r = 0; r < 8; r++)
    begin
      v = $random(seed);
      wr_reg(2'h1, {8'hFF, 1'b1, v[6], 1'b0, r[2:0], v[1:0]});
      rd_reg(2'h1, d);
      `CHK("cr1_region", exp_cr1(v[6], 1'b0, r[2:0]), d)
      `CHK("clk_type", v[6], se_clk)
      g    = n_ref;
      step = row;
      repeat (50) @(posedge clk);
      `CHK("refresh_none", in_area(r[2:0], step), n_ref != g)
    end
    wr_reg(2'h1, 16'hFFC1);
    $display("test regions done");
    wr_reg(2'h0, 16'h8000);
    for (k = 0; k < 100 && ref_act !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 100 && ref_act !== 1'b0; k++) @(negedge clk);
    fork
      psrpc_host_model_i.frame(3, 0, 0);
      begin
        watch();
        `CHK("strobe_plain", 1'b0, rw_data_strobe_out)
      end
    join
    psrpc_host_model_i.frame(6, 0, 0);
    fork
      psrpc_host_model_i.frame(3, 0, 0);
      begin
        watch();
        `CHK("strobe_extra", 1'b1, rw_data_strobe_out)
      end
    join
    `CHK("refresh_in_access", 1'b0, bad_ref)
    fork
      psrpc_host_model_i.frame(3, 20, 1);
      begin
        for (k = 0; k < 60 && cstop !== 1'b1; k++) @(negedge clk);
        `CHK("clock_stop", 1'b1, cstop)
      end
    join
    repeat (4) @(posedge clk);
    `CHK("clock_run", 1'b0, cstop)
    $display("test strobe done");
    wr_reg(2'h1, 16'hFFE1);
    #1 `CHK("sleep_on", 1'b1, slp)
    rd_reg(2'h1, d);
    `CHK("cr1_sleep", exp_cr1(1'b1, 1'b1, 3'h0), d)
    psrpc_host_model_i.frame(0, 2, 0);
    repeat (4) @(posedge clk);
    `CHK("sleep_exit", 1'b0, slp)
    rd_reg(2'h1, d);
    `CHK("cr1_wake", exp_cr1(1'b1, 1'b0, 3'h0), d)
    wr_reg(2'h1, 16'hFFE1);
    @(posedge clk);
    hw_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("sleep_hwrst", 1'b0, slp)
    `CHK("refresh_hwrst", 1'b0, ref_act)
    `CHK("invalid_hwrst", 1'b1, inval)
    g = n_ref;
    repeat (40) @(posedge clk);
    `CHK("refresh_halt", g, n_ref)
    hw_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(2'h2, d);
    `CHK("status_hwrst", 16'h0004, d & 16'h0004)
    `CHK("invalid_clear", 1'b0, inval)
    $display("test sleep done");
    wr_reg(2'h0, 16'h0008);
    for (k = 0; k < 20 && deep_power_down !== 1'b1; k++) @(negedge clk);
    `CHK("dpd_entry", 1'b1, deep_power_down)
    g = n_ref;
    wr_reg(2'h1, 16'hFFE1);
    repeat (50) @(posedge clk);
    `CHK("dpd_no_refresh", g, n_ref)
    `CHK("dpd_ignore", 1'b0, slp)
    psrpc_host_model_i.frame(0, 2, 0);
    repeat (10) @(posedge clk);
    `CHK("dpd_exit", 1'b0, deep_power_down)
    rd_reg(2'h0, d);
    `CHK("cr0_after_dpd", `PSRPC_CR0_RST, d)
    rd_reg(2'h2, d);
    `CHK("data_invalid", 16'h0004, d & 16'h0004)
    fork
      psrpc_host_model_i.frame(3, 0, 0);
      begin
        watch();
        `CHK("strobe_fixed", 1'b1, rw_data_strobe_out)
      end
    join
    wr_reg(2'h0, 16'h0008);
    repeat (20) @(posedge clk);
    hw_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("dpd_hwrst", 1'b0, deep_power_down)
    rd_reg(2'h0, d);
    `CHK("cr0_hwrst", `PSRPC_CR0_RST, d)
    $display("test power down done");
    stop_test();
  end
endmodule // psram_power_refresh_ctrl_bench
